// file: core/eaac_area_sel.sv
`timescale 1ns/1ps
`include "eaac_cfg.svh"
module eaac_area_sel import eaac_pkg::*; (
    eaac_cfg_if.sel cfg, // Stored settings
    input wire logic adv_mode, // High in advanced mode
    input wire logic [23:0] addr, // Cycle address
    input wire eaac_space_t space, // Target space of the cycle
    output logic [2:0] area, // Decoded area
    output logic is_8bit, // Byte-wide bus selected
    output logic is_3state, // Three-state access with waits
    output logic [1:0] waits, // Program wait states
    output logic [2:0] states // Total states of the access
);
    logic [15:0] wait_all;
    logic [1:0] wait_fld [0:7];
    logic is_ext;
    logic [2:0] int_states;

    // Upper register holds areas 7..4, lower 3..0, two bits each
    assign wait_all = {cfg.wait_hi, cfg.wait_lo};
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_area
            assign wait_fld[i] = wait_all[2*i+1 -: 2];
        end
    endgenerate

    // Normal mode forces area 0 so areas 7..1 never take effect
    assign area = adv_mode ? addr[`EAAC_AREA_MSB:`EAAC_AREA_LSB] : 3'h0;
    assign is_ext = (space == EAAC_SP_EXT);
    assign is_8bit = is_ext ? cfg.width[area] : `EAAC_FIXED_8BIT;
    assign is_3state = is_ext && cfg.state[area];
    assign waits = is_3state ? wait_fld[area] : 2'h0;
    assign int_states = (space == EAAC_SP_ROM) ? `EAAC_ROM_STATES : `EAAC_IO_STATES;
    assign states = !is_ext ? int_states :
        (is_3state ? `EAAC_ST_THREE + {1'b0, waits} : `EAAC_ST_TWO);
endmodule : eaac_area_sel

// file: core/eaac_cfg.svh
`ifndef EAAC_CFG_SVH
`define EAAC_CFG_SVH

// Register offsets on the configuration port
`define EAAC_OFF_WIDTH 16'hFED0
`define EAAC_OFF_STATE 16'hFED1
`define EAAC_OFF_WAIT_HI 16'hFED2
`define EAAC_OFF_WAIT_LO 16'hFED3

// Storage indices
`define EAAC_IDX_WIDTH 0
`define EAAC_IDX_STATE 1
`define EAAC_IDX_WAIT_HI 2
`define EAAC_IDX_WAIT_LO 3
`define EAAC_NUM_REGS 4

// Initial values
`define EAAC_RST_WIDTH 8'hFF
`define EAAC_RST_WIDTH_MODE4 8'h00
`define EAAC_RST_STATE 8'hFF
`define EAAC_RST_WAIT 8'hFF
`define EAAC_MODE_ZERO_WIDTH 3'h4

// Area decode: eight 2-Mbyte areas of a 24-bit space
`define EAAC_AREA_MSB 23
`define EAAC_AREA_LSB 21

// State counts per access
`define EAAC_ST_TWO 3'h2
`define EAAC_ST_THREE 3'h3
`define EAAC_ROM_STATES 3'h1
`define EAAC_IO_STATES 3'h2
`define EAAC_FIXED_8BIT 1'h0

`endif

// file: core/eaac_cfg_if.sv
`timescale 1ns/1ps
interface eaac_cfg_if;
    logic [7:0] width;
    logic [7:0] state;
    logic [7:0] wait_hi;
    logic [7:0] wait_lo;
    modport regs (output width, output state, output wait_hi, output wait_lo);
    modport sel (input width, input state, input wait_hi, input wait_lo);
endinterface : eaac_cfg_if

// file: core/eaac_pkg.sv
package eaac_pkg;
    typedef enum logic [1:0] {EAAC_SP_EXT, EAAC_SP_ROM, EAAC_SP_IO} eaac_space_t;
    typedef enum logic {EAAC_SEQ_IDLE, EAAC_SEQ_RUN} eaac_seq_t;
endpackage : eaac_pkg

// file: core/eaac_regs.sv
`timescale 1ns/1ps
`include "eaac_cfg.svh"
module eaac_regs import eaac_pkg::*; (
    input wire logic clock, // System clock
    input wire logic rst_n, // Power-on reset
    input wire logic hw_stby, // Hardware standby
    input wire logic [2:0] op_mode, // Operating mode pins
    input wire logic [3:0] wr_en, // Per-register write strobe
    input wire logic [7:0] wdata, // Write data
    eaac_cfg_if.regs cfg // Stored settings
);
    logic [7:0] reg_q [0:`EAAC_NUM_REGS-1];
    logic [7:0] rst_val [0:`EAAC_NUM_REGS-1];
    logic init;

    // Only power-on and hardware standby reinitialise; manual reset never reaches here
    assign init = !rst_n || hw_stby;
    assign rst_val[`EAAC_IDX_WIDTH] = (op_mode == `EAAC_MODE_ZERO_WIDTH) ?
        `EAAC_RST_WIDTH_MODE4 : `EAAC_RST_WIDTH;
    assign rst_val[`EAAC_IDX_STATE] = `EAAC_RST_STATE;
    assign rst_val[`EAAC_IDX_WAIT_HI] = `EAAC_RST_WAIT;
    assign rst_val[`EAAC_IDX_WAIT_LO] = `EAAC_RST_WAIT;

    genvar i;
    generate
        for (i = 0; i < `EAAC_NUM_REGS; i++) begin : g_reg
            always_ff @(posedge clock) begin
                if (init) begin
                    reg_q[i] <= rst_val[i];
                end else if (wr_en[i]) begin
                    reg_q[i] <= wdata;
                end
            end
        end
    endgenerate

    assign cfg.width = reg_q[`EAAC_IDX_WIDTH];
    assign cfg.state = reg_q[`EAAC_IDX_STATE];
    assign cfg.wait_hi = reg_q[`EAAC_IDX_WAIT_HI];
    assign cfg.wait_lo = reg_q[`EAAC_IDX_WAIT_LO];

    por_width_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) && !hw_stby |-> cfg.width ==
        (($past(op_mode) == `EAAC_MODE_ZERO_WIDTH) ? 8'h00 : 8'hFF))
        else $error("width register wrong after power-on");
    por_state_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) && !hw_stby |-> cfg.state == 8'hFF)
        else $error("access state register wrong after power-on");
    por_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(hw_stby) |-> {cfg.wait_hi, cfg.wait_lo} == 16'hFFFF)
        else $error("wait registers wrong after standby");
endmodule : eaac_regs

// file: core/eaac_top.sv
// Notes on behaviour
// - Width bit: 0 sixteen-bit, 1 eight-bit
// - Width init FF, mode 4 gives 00
// - Manual reset and software standby keep registers
// - Internal spaces ignore the width bits
// - Normal mode uses area 0 settings only
// - State bit: 0 two-state, 1 three-state
// - State register initialises to all ones
// - Internal spaces ignore the state bits
// - Wait field adds zero to three waits
// - Upper register areas 7-4, lower 3-0
// - No program waits on internal spaces
// - Both wait registers initialise to all ones
// - All four registers are eight-bit read/write
// - Advanced mode: eight areas of 2 Mbytes
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "eaac_cfg.svh"
module eaac_top import eaac_pkg::*; (
    input wire logic clock, // System clock, 125 MHz
    input wire logic rst_n, // Power-on reset, synchronous
    input wire logic hw_stby, // Hardware standby, high active
    input wire logic man_rst_n, // Manual reset
    input wire logic sw_stby, // Software standby, high active
    input wire logic [2:0] op_mode, // Operating mode pins
    input wire logic adv_mode, // High in advanced mode
    input wire logic [15:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic cyc_start, // Bus cycle request pulse
    input wire logic [23:0] cyc_addr, // Bus cycle address
    input wire eaac_space_t cyc_space, // Bus cycle target space
    input wire logic wait_req_n, // External wait request
    output logic [2:0] cyc_area, // Area of current cycle
    output logic cyc_8bit, // Byte-wide bus for current cycle
    output logic cyc_3state, // Three-state access of current cycle
    output logic [1:0] cyc_waits, // Program waits of current cycle
    output logic cyc_busy, // Bus cycle in progress
    output logic cyc_done // Cycle finished, one pulse
);
    eaac_cfg_if cfg_bus ();

    logic por;
    logic seq_clr;
    logic [3:0] wr_hit;
    logic [3:0] rd_hit;
    logic [7:0] rd_mux;
    logic [2:0] sel_area;
    logic sel_8bit;
    logic sel_3state;
    logic [1:0] sel_waits;
    logic [2:0] sel_states;

    eaac_seq_t seq_q;
    eaac_seq_t seq_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [2:0] area_q;
    logic bit8_q;
    logic st3_q;
    logic [1:0] waits_q;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic start_ok;
    logic run;
    logic wait_hold;
    logic last;

    // Register port decode
    assign por = !rst_n || hw_stby;
    assign wr_hit[`EAAC_IDX_WIDTH] = reg_wr && (reg_addr == `EAAC_OFF_WIDTH);
    assign wr_hit[`EAAC_IDX_STATE] = reg_wr && (reg_addr == `EAAC_OFF_STATE);
    assign wr_hit[`EAAC_IDX_WAIT_HI] = reg_wr && (reg_addr == `EAAC_OFF_WAIT_HI);
    assign wr_hit[`EAAC_IDX_WAIT_LO] = reg_wr && (reg_addr == `EAAC_OFF_WAIT_LO);
    assign rd_hit[`EAAC_IDX_WIDTH] = (reg_addr == `EAAC_OFF_WIDTH);
    assign rd_hit[`EAAC_IDX_STATE] = (reg_addr == `EAAC_OFF_STATE);
    assign rd_hit[`EAAC_IDX_WAIT_HI] = (reg_addr == `EAAC_OFF_WAIT_HI);
    assign rd_hit[`EAAC_IDX_WAIT_LO] = (reg_addr == `EAAC_OFF_WAIT_LO);

    // Unmapped addresses read as zero
    assign rd_mux = ({8{rd_hit[`EAAC_IDX_WIDTH]}} & cfg_bus.width) |
                    ({8{rd_hit[`EAAC_IDX_STATE]}} & cfg_bus.state) |
                    ({8{rd_hit[`EAAC_IDX_WAIT_HI]}} & cfg_bus.wait_hi) |
                    ({8{rd_hit[`EAAC_IDX_WAIT_LO]}} & cfg_bus.wait_lo);
    assign rdata_d = reg_rd ? rd_mux : 8'h00;

    eaac_regs u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .hw_stby(hw_stby),
        .op_mode(op_mode),
        .wr_en(wr_hit),
        .wdata(reg_wdata),
        .cfg(cfg_bus.regs)
    );

    eaac_area_sel u_sel (
        .cfg(cfg_bus.sel),
        .adv_mode(adv_mode),
        .addr(cyc_addr),
        .space(cyc_space),
        .area(sel_area),
        .is_8bit(sel_8bit),
        .is_3state(sel_3state),
        .waits(sel_waits),
        .states(sel_states)
    );

    // Manual reset and software standby abort the cycle but leave the settings alone
    assign seq_clr = por || !man_rst_n || sw_stby;

    // A request during a running cycle is ignored; the master must wait for done
    assign run = (seq_q == EAAC_SEQ_RUN);
    assign start_ok = cyc_start && !run;
    // The wait pin only stretches the last state of a three-state access
    assign wait_hold = run && st3_q && !wait_req_n && (cnt_q == 3'h1);
    assign last = run && (cnt_q == 3'h1) && !wait_hold;

    assign seq_d = start_ok ? EAAC_SEQ_RUN : (last ? EAAC_SEQ_IDLE : seq_q);
    assign cnt_d = start_ok ? sel_states :
                   ((run && (cnt_q != 3'h1)) ? cnt_q - 3'h1 : cnt_q);
    assign busy_d = (seq_d == EAAC_SEQ_RUN);

    always_ff @(posedge clock) begin
        if (seq_clr) begin
            seq_q <= EAAC_SEQ_IDLE;
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= last;
        end
    end

    // Settings are frozen at the start so a register write mid-cycle cannot tear it
    always_ff @(posedge clock) begin
        if (seq_clr) begin
            area_q <= 3'h0;
            bit8_q <= 1'b0;
            st3_q <= 1'b0;
            waits_q <= 2'h0;
        end else if (start_ok) begin
            area_q <= sel_area;
            bit8_q <= sel_8bit;
            st3_q <= sel_3state;
            waits_q <= sel_waits;
        end
    end

    always_ff @(posedge clock) begin
        if (por) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign cyc_area = area_q;
    assign cyc_8bit = bit8_q;
    assign cyc_3state = st3_q;
    assign cyc_waits = waits_q;
    assign cyc_busy = busy_q;
    assign cyc_done = done_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (seq_clr);

    sequence ext_start_s;
        start_ok && (cyc_space == EAAC_SP_EXT);
    endsequence

    sequence int_start_s;
        start_ok && (cyc_space != EAAC_SP_EXT);
    endsequence

    sequence two_state_run_s;
        cyc_busy [*2] ##1 (!cyc_busy && cyc_done);
    endsequence

    width_pick_a: assert property (
        ext_start_s |=> cyc_8bit == $past(cfg_bus.width[sel_area]))
        else $error("bus width not taken from area width bit");

    width_int_a: assert property (
        int_start_s |=> !cyc_8bit)
        else $error("internal access used programmable width");

    normal_area_a: assert property (
        start_ok && !adv_mode |=> cyc_area == 3'h0 &&
        cyc_3state == ($past(cfg_bus.state[0]) && $past(cyc_space) == EAAC_SP_EXT))
        else $error("normal mode used an area other than 0");

    two_state_a: assert property (
        ext_start_s ##0 !cfg_bus.state[sel_area] |=> !cyc_3state && cyc_waits == 2'h0
        ##0 two_state_run_s)
        else $error("two-state access did not take two states");

    state_int_a: assert property (
        int_start_s |=> !cyc_3state)
        else $error("internal access used programmable state count");

    wait_count_a: assert property (
        ext_start_s ##0 cfg_bus.state[sel_area] |=> cnt_q == 3'h3 + {1'b0, cyc_waits})
        else $error("three-state access length wrong");

    wait_layout_a: assert property (
        ext_start_s ##0 adv_mode && cyc_addr[23:21] == 3'h5 && cfg_bus.state[5]
        |=> cyc_waits == $past(cfg_bus.wait_hi[3:2]))
        else $error("area 5 wait field taken from wrong bits");

    wait_int_a: assert property (
        int_start_s |=> cyc_waits == 2'h0 && cyc_busy)
        else $error("program waits on internal access");

    reg_rw_a: assert property (
        reg_wr && reg_addr == `EAAC_OFF_WAIT_LO ##1 reg_rd && reg_addr == `EAAC_OFF_WAIT_LO
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("register did not read back written value");

    area_map_a: assert property (
        start_ok && adv_mode |=> cyc_area == $past(cyc_addr[23:21]))
        else $error("advanced mode area decode wrong");

    wait_pin_a: assert property (
        cyc_busy && !cyc_3state && cnt_q == 3'h1 |=> !cyc_busy && cyc_done)
        else $error("wait pin stretched a two-state access");

    keep_man_a: assert property (@(posedge clock) disable iff (por)
        (!man_rst_n || sw_stby) && !reg_wr |=> $stable(cfg_bus.width) &&
        $stable(cfg_bus.state) && $stable(cfg_bus.wait_hi) && $stable(cfg_bus.wait_lo))
        else $error("settings changed by manual reset or software standby");

endmodule : eaac_top

// file: tb/eaac_ext_mem.sv
`timescale 1ns/1ps
module eaac_ext_mem (
    input wire logic clock, // System clock
    input wire logic rst_n, // Power-on reset
    input wire logic cyc_busy, // Bus cycle in progress
    input wire logic [3:0] lead, // Busy edges before the stall starts
    input wire logic [3:0] stall, // Length of the wait request
    output logic wait_req_n // Wait request, pulled up when idle
);
    logic [4:0] seen_q;
    logic [4:0] seen_d;
    logic hold_low;

    assign seen_d = seen_q + 5'h01;
    // Aimed at the final state; earlier low cycles would not stretch the access
    assign hold_low = (seen_d >= {1'b0, lead}) && (seen_d < ({1'b0, lead} + {1'b0, stall}));

    always_ff @(posedge clock) begin
        if (!rst_n || !cyc_busy) begin
            seen_q <= 5'h00;
            wait_req_n <= 1'b1;
        end else begin
            seen_q <= seen_d;
            wait_req_n <= !hold_low;
        end
    end
endmodule : eaac_ext_mem

// file: tb/eaac_top_tb.sv
`timescale 1ns/1ps
`include "eaac_cfg.svh"
module eaac_top_tb import eaac_pkg::*;;
    logic clock, rst_n, hw_stby, man_rst_n, sw_stby, adv_mode, reg_wr, reg_rd, cyc_start;
    logic wait_req_n, cyc_8bit, cyc_3state, cyc_busy, cyc_done;
    logic [2:0] op_mode, cyc_area;
    logic [1:0] cyc_waits;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cfg_w, cfg_s, cfg_h, cfg_l;
    logic [23:0] cyc_addr;
    logic [3:0] lead, stall;
    eaac_space_t cyc_space;
    int bad_count, cmp_count, tick_count;

    eaac_top DUT (.clock(clock), .rst_n(rst_n), .hw_stby(hw_stby), .man_rst_n(man_rst_n),
        .sw_stby(sw_stby), .op_mode(op_mode), .adv_mode(adv_mode), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cyc_start(cyc_start), .cyc_addr(cyc_addr), .cyc_space(cyc_space),
        .wait_req_n(wait_req_n), .cyc_area(cyc_area), .cyc_8bit(cyc_8bit),
        .cyc_3state(cyc_3state), .cyc_waits(cyc_waits), .cyc_busy(cyc_busy),
        .cyc_done(cyc_done));
    eaac_ext_mem ext (.clock(clock), .rst_n(rst_n), .cyc_busy(cyc_busy), .lead(lead),
        .stall(stall), .wait_req_n(wait_req_n));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        tick_count++;
        if (tick_count > 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task read_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check("register read", exp, reg_rdata);
    endtask : read_chk

    task read_all(input logic [7:0] w, s, h, l);
        read_chk(`EAAC_OFF_WIDTH, w);
        read_chk(`EAAC_OFF_STATE, s);
        read_chk(`EAAC_OFF_WAIT_HI, h);
        read_chk(`EAAC_OFF_WAIT_LO, l);
    endtask : read_all

    task load_cfg(input logic [7:0] w, s, h, l);
        reg_write(`EAAC_OFF_WIDTH, w);
        reg_write(`EAAC_OFF_STATE, s);
        reg_write(`EAAC_OFF_WAIT_HI, h);
        reg_write(`EAAC_OFF_WAIT_LO, l);
        cfg_w = w;
        cfg_s = s;
        cfg_h = h;
        cfg_l = l;
    endtask : load_cfg

    task do_reset(input logic [2:0] m);
        @(posedge clock);
        rst_n <= 1'b0;
        op_mode <= m;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
    endtask : do_reset

    task run_cycle(input logic [23:0] a, input eaac_space_t sp, input logic [2:0] ar,
                   input logic w8, s3, input logic [1:0] wt, input int dly,
                   input logic [3:0] st);
        int k;
        @(posedge clock);
        cyc_start <= 1'b1;
        cyc_addr <= a;
        cyc_space <= sp;
        // Lead lines the stall up with the last state of the access
        lead <= s3 ? {2'b00, wt} + 4'h2 : 4'h1;
        stall <= st;
        @(posedge clock);
        cyc_start <= 1'b0;
        @(negedge clock);
        check("busy", 8'h01, {7'h00, cyc_busy});
        k = 0;
        do begin
            @(posedge clock);
            k++;
            @(negedge clock);
        end while (cyc_done !== 1'b1 && k < 40);
        check("done delay", dly[7:0], k[7:0]);
        check("busy at done", 8'h00, {7'h00, cyc_busy});
        if (sp == EAAC_SP_EXT) check("area", {5'h00, ar}, {5'h00, cyc_area});
        check("byte bus", {7'h00, w8}, {7'h00, cyc_8bit});
        check("three state", {7'h00, s3}, {7'h00, cyc_3state});
        check("waits", {6'h00, wt}, {6'h00, cyc_waits});
    endtask : run_cycle

    task t_reset_values;
        do_reset(3'h1);
        read_all(8'hFF, 8'hFF, 8'hFF, 8'hFF);
    endtask : t_reset_values

    // Write then read with no gap between the strobes
    task wr_rd_chk(input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= `EAAC_OFF_WAIT_LO;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check("back to back read", d, reg_rdata);
    endtask : wr_rd_chk

    task t_read_write;
        load_cfg(8'h5A, 8'hA5, 8'h3C, 8'hC3);
        read_all(8'h5A, 8'hA5, 8'h3C, 8'hC3);
        reg_write(16'hFED4, 8'h77);
        read_chk(16'hFED4, 8'h00);
        wr_rd_chk(8'h96);
        wr_rd_chk(8'hC3);
    endtask : t_read_write

    task t_retain;
        @(posedge clock);
        man_rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        man_rst_n <= 1'b1;
        sw_stby <= 1'b1;
        repeat (3) @(posedge clock);
        sw_stby <= 1'b0;
        read_all(8'h5A, 8'hA5, 8'h3C, 8'hC3);
        @(posedge clock);
        op_mode <= 3'h4;
        hw_stby <= 1'b1;
        repeat (3) @(posedge clock);
        hw_stby <= 1'b0;
        op_mode <= 3'h1;
        read_all(8'h00, 8'hFF, 8'hFF, 8'hFF);
    endtask : t_retain

    task t_areas;
        logic w8, s3;
        logic [1:0] wt;
        adv_mode <= 1'b1;
        load_cfg(8'hA5, 8'hEB, 8'h1B, 8'hE4);
        for (int a = 0; a < 8; a++) begin
            w8 = cfg_w[a];
            s3 = cfg_s[a];
            wt = !s3 ? 2'h0 : (a >= 4 ? cfg_h[2*(a-4) +: 2] : cfg_l[2*a +: 2]);
            // Each area lives in its own 2-Mbyte slice
            run_cycle({a[2:0], 21'h0ABCDE}, EAAC_SP_EXT, a[2:0], w8, s3, wt,
                      s3 ? 3 + wt : 2, 4'h0);
        end
    endtask : t_areas

    task t_wait_pin;
        run_cycle(24'h200010, EAAC_SP_EXT, 3'h1, 1'b0, 1'b1, 2'h1, 6, 4'h2);
        run_cycle(24'h400010, EAAC_SP_EXT, 3'h2, 1'b1, 1'b0, 2'h0, 2, 4'h2);
    endtask : t_wait_pin

    task t_normal;
        adv_mode <= 1'b0;
        run_cycle(24'hA00020, EAAC_SP_EXT, 3'h0, 1'b1, 1'b1, 2'h0, 3, 4'h0);
    endtask : t_normal

    task t_internal;
        adv_mode <= 1'b1;
        load_cfg(8'hFF, 8'hFF, 8'hFF, 8'hFF);
        run_cycle(24'h600040, EAAC_SP_ROM, 3'h3, 1'b0, 1'b0, 2'h0, 1, 4'h0);
        run_cycle(24'hE00040, EAAC_SP_IO, 3'h7, 1'b0, 1'b0, 2'h0, 2, 4'h0);
    endtask : t_internal

    initial begin
        rst_n <= 1'b0;
        hw_stby <= 1'b0;
        man_rst_n <= 1'b1;
        sw_stby <= 1'b0;
        op_mode <= 3'h1;
        adv_mode <= 1'b1;
        reg_addr <= 16'h0000;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        cyc_start <= 1'b0;
        cyc_addr <= 24'h000000;
        cyc_space <= EAAC_SP_EXT;
        lead <= 4'h0;
        stall <= 4'h0;
        t_reset_values();
        t_read_write();
        t_retain();
        t_areas();
        t_wait_pin();
        t_normal();
        t_internal();
        report_and_stop();
    end
endmodule : eaac_top_tb
